/* File: chi_pkg.sv */
// Purpose: Shared constants and types for the caption host interface.
// Assumes: Serial bus pins are sampled synchronously to mclk.
// Notes:   Subaddresses, control register one field positions and the control reset value live here only.
`default_nettype none

package chi_pkg;

	// ----------------------------------------------------------------
	// Subaddress map
	// ----------------------------------------------------------------
	localparam logic [2:0] CHI_SUB_CTRL0 = 3'h0;
	localparam logic [2:0] CHI_SUB_CTRL1 = 3'h1;
	localparam logic [2:0] CHI_SUB_ROW = 3'h2;
	localparam logic [2:0] CHI_SUB_COL = 3'h3;
	localparam logic [2:0] CHI_SUB_OSD = 3'h4;
	localparam logic [2:0] CHI_SUB_WR_LAST = 3'h4;
	localparam logic [2:0] CHI_SUB_RD_STATUS = 3'h0;
	localparam logic [2:0] CHI_SUB_RD_BYTE1 = 3'h1;
	localparam logic [2:0] CHI_SUB_RD_LAST = 3'h2;
	localparam logic [7:0] CHI_REG_RESET = 8'h00;
	localparam logic [6:0] CHI_DEV_ADDR_DEFAULT = 7'h3a;
	localparam logic [4:0] CHI_COL_LAST = 5'h1f;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CHI_C1_MODE_LO = 0;
	localparam int CHI_C1_MODE_HI = 1;
	localparam int CHI_C1_ENH_LO = 2;
	localparam int CHI_C1_ENH_HI = 3;
	localparam int CHI_C1_ACQ_OFF = 4;
	localparam int CHI_C1_WIDE = 5;
	localparam int CHI_C1_CHAN2 = 6;
	localparam int CHI_C1_CLEAR = 7;
	localparam int CHI_ROW_W = 4;
	localparam int CHI_COL_W = 5;
	localparam int CHI_OSD_W = 7;

	// ----------------------------------------------------------------
	// Serial engine states
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		CHI_ST_IDLE,
		CHI_ST_ADDR,
		CHI_ST_ACK,
		CHI_ST_WR,
		CHI_ST_RD,
		CHI_ST_RD_ACK
	} chi_bus_state_t;

	// Advance a subaddress pointer, holding at its last value
	function automatic logic [2:0] chi_next_ptr(input logic [2:0] ptr, input logic [2:0] last);
		chi_next_ptr = (ptr == last) ? last : ptr + 3'h1;
	endfunction

endpackage

`default_nettype wire

/* File: chi_byte_if.sv */
// Purpose: Byte-level handshake between serial engine and register side.
// Assumes: All signals belong to the mclk domain.
// Notes:   Strobes are one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none

interface chi_byte_if;
	logic busy;
	logic wr_stb;
	logic wr_first;
	logic [7:0] wr_data;
	logic rd_taken;
	logic [7:0] rd_data;

	modport engine (output busy, output wr_stb, output wr_first, output wr_data,
		output rd_taken, input rd_data);
	modport regs (input busy, input wr_stb, input wr_first, input wr_data,
		input rd_taken, output rd_data);
endinterface

`default_nettype wire

/* File: chi_bus_engine.sv */
// Purpose: Two-wire serial slave engine turning bus bits into byte strobes.
// Assumes: scl_in and sda_in are already synchronous to mclk.
// Notes:   Only pulls SDA low; the pin itself is open drain.
`timescale 1ns/1ps
`default_nettype none

module chi_bus_engine
	import chi_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = chi_pkg::CHI_DEV_ADDR_DEFAULT
)
(
	// Clock and reset
	input wire logic mclk,
	input wire logic reset,
	// Bus pins
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_oe,
	// Byte side
	chi_byte_if.engine bus
);

	chi_bus_state_t state_ff, nxt_state;
	logic [2:0] bit_ff, nxt_bit;
	logic [7:0] shift_ff, nxt_shift;
	logic rw_ff, nxt_rw;
	logic ack_ff, nxt_ack;
	logic oe_ff, nxt_oe;
	logic first_ff, nxt_first;
	logic wr_first_ff, nxt_wr_first;
	logic wr_stb_ff, nxt_wr_stb;
	logic rd_taken_ff, nxt_rd_taken;
	logic scl_d_ff, sda_d_ff;
	logic scl_rise, scl_fall, start_c, stop_c;

	// ----------------------------------------------------------------
	// Bus conditions
	// ----------------------------------------------------------------
	// SDA moving while SCL stays high marks start or stop
	assign scl_rise = scl_in & ~scl_d_ff;
	assign scl_fall = ~scl_in & scl_d_ff;
	assign start_c = scl_in & scl_d_ff & sda_d_ff & ~sda_in;
	assign stop_c = scl_in & scl_d_ff & ~sda_d_ff & sda_in;

	assign sda_oe = oe_ff;
	assign bus.busy = (state_ff != CHI_ST_IDLE);
	assign bus.wr_stb = wr_stb_ff;
	assign bus.wr_first = wr_first_ff;
	assign bus.wr_data = shift_ff;
	assign bus.rd_taken = rd_taken_ff;

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	// Acknowledge spans two SCL falls: pull at the first; at the next, release, or drive the first read bit on a read
	always_comb
	begin
		nxt_state = state_ff;
		nxt_bit = bit_ff;
		nxt_shift = shift_ff;
		nxt_rw = rw_ff;
		nxt_ack = ack_ff;
		nxt_oe = oe_ff;
		nxt_first = first_ff;
		nxt_wr_first = wr_first_ff;
		nxt_wr_stb = 1'b0;
		nxt_rd_taken = 1'b0;
		if (start_c)
		begin
			nxt_state = CHI_ST_ADDR;
			nxt_bit = 3'h0;
			nxt_oe = 1'b0;
			nxt_ack = 1'b0;
		end
		else if (stop_c)
		begin
			nxt_state = CHI_ST_IDLE;
			nxt_oe = 1'b0;
			nxt_ack = 1'b0;
		end
		else
		begin
			case (state_ff)
				CHI_ST_IDLE: nxt_oe = 1'b0;
				CHI_ST_ADDR, CHI_ST_WR:
					if (scl_rise)
					begin
						nxt_shift = {shift_ff[6:0], sda_in};
						nxt_bit = bit_ff + 3'h1;
						if (bit_ff == 3'h7)
						begin
							nxt_state = CHI_ST_ACK;
							if (state_ff == CHI_ST_WR)
							begin
								nxt_wr_stb = 1'b1;
								nxt_wr_first = first_ff;
								nxt_first = 1'b0;
								nxt_rw = 1'b0;
							end
							else if (shift_ff[6:0] == DEV_ADDR)
							begin
								nxt_rw = sda_in;
								nxt_first = 1'b1;
							end
							else
								nxt_state = CHI_ST_IDLE; // Not our address
						end
					end
				CHI_ST_ACK:
					if (scl_fall)
					begin
						nxt_ack = ~ack_ff;
						nxt_oe = ~ack_ff;
						if (ack_ff && rw_ff)
						begin
							nxt_shift = bus.rd_data;
							nxt_oe = ~bus.rd_data[7];
							nxt_bit = 3'h0;
							nxt_rd_taken = 1'b1;
							nxt_state = CHI_ST_RD;
						end
						else if (ack_ff)
						begin
							nxt_bit = 3'h0;
							nxt_state = CHI_ST_WR;
						end
					end
				CHI_ST_RD:
				begin
					if (scl_fall)
					begin
						nxt_shift = {shift_ff[6:0], 1'b0};
						nxt_oe = ~shift_ff[6];
					end
					if (scl_rise)
					begin
						nxt_bit = bit_ff + 3'h1;
						if (bit_ff == 3'h7)
						begin
							nxt_state = CHI_ST_RD_ACK;
							nxt_ack = 1'b0;
						end
					end
				end
				CHI_ST_RD_ACK:
					if (scl_fall && !ack_ff)
						nxt_oe = 1'b0;
					else if (scl_rise)
					begin
						// Master not-acknowledge ends the read
						if (sda_in)
							nxt_state = CHI_ST_IDLE;
						else
							nxt_ack = 1'b1;
					end
					else if (scl_fall)
					begin
						nxt_shift = bus.rd_data;
						nxt_oe = ~bus.rd_data[7];
						nxt_bit = 3'h0;
						nxt_ack = 1'b0;
						nxt_rd_taken = 1'b1;
						nxt_state = CHI_ST_RD;
					end
				default: nxt_state = CHI_ST_IDLE;
			endcase
		end
	end

	// Registers
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			state_ff <= CHI_ST_IDLE;
			bit_ff <= 3'h0;
			shift_ff <= 8'h00;
			rw_ff <= 1'b0;
			ack_ff <= 1'b0;
			oe_ff <= 1'b0;
			first_ff <= 1'b0;
			wr_first_ff <= 1'b0;
			wr_stb_ff <= 1'b0;
			rd_taken_ff <= 1'b0;
			scl_d_ff <= 1'b1;
			sda_d_ff <= 1'b1;
		end
		else
		begin
			state_ff <= nxt_state;
			bit_ff <= nxt_bit;
			shift_ff <= nxt_shift;
			rw_ff <= nxt_rw;
			ack_ff <= nxt_ack;
			oe_ff <= nxt_oe;
			first_ff <= nxt_first;
			wr_first_ff <= nxt_wr_first;
			wr_stb_ff <= nxt_wr_stb;
			rd_taken_ff <= nxt_rd_taken;
			scl_d_ff <= scl_in;
			sda_d_ff <= sda_in;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_stop_releases: assert property (@(posedge mclk) disable iff (reset)
		stop_c |=> (state_ff == CHI_ST_IDLE) && !oe_ff)
		else $error("stop did not return engine to idle");
	c_write_byte: cover property (@(posedge mclk) disable iff (reset) wr_stb_ff && !wr_first_ff);
	c_read_byte: cover property (@(posedge mclk) disable iff (reset) rd_taken_ff);

endmodule // chi_bus_engine

`default_nettype wire

/* File: chi_caption_host_interface.sv */
// Purpose: Host control interface of a line-21 caption device.
// Assumes: Pins synchronous to mclk; acquisition logic feeds acq_* ports.
// Notes:   Contract
`timescale 1ns/1ps
`default_nettype none

module chi_caption_host_interface
	import chi_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = chi_pkg::CHI_DEV_ADDR_DEFAULT
)
(
	// Clock and reset
	input wire logic mclk,
	input wire logic reset,
	// Serial bus pins
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// Data-ready pin
	input wire logic data_ready_n_in,
	output logic data_ready_n_out,
	output logic data_ready_n_oe,
	// Operating controls
	input wire logic standalone_mode,
	input wire logic dr_out_enable,
	// From acquisition
	input wire logic acq_new_data,
	input wire logic acq_parity_shutdown,
	input wire logic acq_eds,
	input wire logic acq_field2,
	input wire logic [7:0] acq_byte1,
	input wire logic [7:0] acq_byte2,
	// Configuration outputs
	output logic [7:0] ctrl0,
	output logic display_mode_hi,
	output logic display_mode_lo,
	output logic caption_ch2,
	output logic [1:0] enh_mode,
	output logic acq_off,
	output logic wide_window,
	output logic clear_page,
	// On-screen display outputs
	output logic [chi_pkg::CHI_ROW_W-1:0] osd_row,
	output logic [chi_pkg::CHI_COL_W-1:0] osd_col,
	output logic [chi_pkg::CHI_OSD_W-1:0] osd_data,
	output logic osd_wr
);

	import chi_pkg::*;

	// Reserved address ranges cannot be served
	if (DEV_ADDR[6:3] == 4'h0 || DEV_ADDR[6:3] == 4'hf)
		$error("DEV_ADDR lies in a reserved address range");

	chi_byte_if bus();
	logic engine_oe;

	chi_bus_engine #(.DEV_ADDR(DEV_ADDR)) u_engine (
		.mclk(mclk),
		.reset(reset),
		.scl_in(scl_in),
		.sda_in(sda_in),
		.sda_oe(engine_oe),
		.bus(bus)
	);

	logic [7:0] ctrl0_ff, nxt_ctrl0, ctrl1_ff, nxt_ctrl1;
	logic [CHI_ROW_W-1:0] row_ff, nxt_row;
	logic [CHI_COL_W-1:0] col_ff, nxt_col;
	logic [CHI_OSD_W-1:0] osd_ff, nxt_osd;
	logic osd_wr_ff, nxt_osd_wr;
	logic [2:0] wr_ptr_ff, nxt_wr_ptr, rd_ptr_ff, nxt_rd_ptr;
	logic stat_ready_ff, stat_pshut_ff, stat_eds_ff, stat_field_ff, stat_por_ff;
	logic nxt_ready, nxt_pshut, nxt_eds, nxt_field, nxt_por;
	logic [7:0] data1_ff, nxt_data1, data2_ff, nxt_data2;
	logic rd_clear;
	logic [2:0] strap_ff, nxt_strap;
	logic mode_hi_ff, mode_lo_ff, ch2_ff, nxt_mode_hi, nxt_mode_lo, nxt_ch2;
	logic dr_out_ff, dr_oe_ff, sda_oe_ff;

	// ----------------------------------------------------------------
	// Write registers and pointers
	// ----------------------------------------------------------------
	// Host writes are ignored in stand-alone mode, where the pins are straps
	always_comb
	begin
		nxt_ctrl0 = ctrl0_ff;
		nxt_ctrl1 = ctrl1_ff;
		nxt_row = row_ff;
		nxt_col = col_ff;
		nxt_osd = osd_ff;
		nxt_osd_wr = 1'b0;
		nxt_wr_ptr = wr_ptr_ff;
		nxt_rd_ptr = rd_ptr_ff;
		rd_clear = 1'b0;
		if (bus.wr_stb && !standalone_mode)
		begin
			if (bus.wr_first)
			begin
				// Out-of-range subaddresses park at the last register
				nxt_wr_ptr = (bus.wr_data > {5'h00, CHI_SUB_WR_LAST}) ? CHI_SUB_WR_LAST
					: bus.wr_data[2:0];
				nxt_rd_ptr = (bus.wr_data > {5'h00, CHI_SUB_RD_LAST}) ? CHI_SUB_RD_LAST
					: bus.wr_data[2:0];
			end
			else
			begin
				case (wr_ptr_ff)
					CHI_SUB_CTRL0: nxt_ctrl0 = bus.wr_data;
					CHI_SUB_CTRL1: nxt_ctrl1 = bus.wr_data;
					CHI_SUB_ROW: nxt_row = bus.wr_data[CHI_ROW_W-1:0];
					CHI_SUB_COL: nxt_col = bus.wr_data[CHI_COL_W-1:0];
					CHI_SUB_OSD:
					begin
						nxt_osd = bus.wr_data[CHI_OSD_W-1:0];
						nxt_osd_wr = 1'b1;
						nxt_col = col_ff + 5'h01; // Column wraps into next row
						if (col_ff == CHI_COL_LAST)
							nxt_row = row_ff + 4'h1;
					end
					default: nxt_osd_wr = 1'b0;
				endcase
				nxt_wr_ptr = chi_next_ptr(wr_ptr_ff, CHI_SUB_WR_LAST);
			end
		end
		if (bus.rd_taken)
		begin
			rd_clear = (rd_ptr_ff == CHI_SUB_RD_STATUS);
			nxt_rd_ptr = chi_next_ptr(rd_ptr_ff, CHI_SUB_RD_LAST);
		end
	end

	// Read byte selected by the read pointer
	always_comb
	begin
		case (rd_ptr_ff)
			CHI_SUB_RD_STATUS:
				bus.rd_data = {stat_por_ff, 3'h0, stat_field_ff, stat_eds_ff,
					stat_pshut_ff, stat_ready_ff};
			CHI_SUB_RD_BYTE1: bus.rd_data = data1_ff;
			default: bus.rd_data = data2_ff;
		endcase
	end

	// ----------------------------------------------------------------
	// Status, straps and pins
	// ----------------------------------------------------------------
	// A new event in the clearing cycle survives: set beats clear
	always_comb
	begin
		nxt_ready = (stat_ready_ff & ~rd_clear) | acq_new_data;
		nxt_pshut = (stat_pshut_ff & ~rd_clear) | acq_parity_shutdown;
		nxt_eds = (stat_eds_ff & ~rd_clear) | (acq_new_data & acq_eds);
		nxt_field = (stat_field_ff & ~rd_clear) | (acq_new_data & acq_field2);
		nxt_por = stat_por_ff & ~rd_clear;
		nxt_data1 = acq_new_data ? acq_byte1 : data1_ff;
		nxt_data2 = acq_new_data ? acq_byte2 : data2_ff;
		// Straps only follow the pins while no transfer is running
		nxt_strap = (standalone_mode && !bus.busy) ? {data_ready_n_in, scl_in, sda_in}
			: strap_ff;
		nxt_mode_hi = standalone_mode ? strap_ff[1] : ctrl1_ff[CHI_C1_MODE_HI];
		nxt_mode_lo = standalone_mode ? strap_ff[0] : ctrl1_ff[CHI_C1_MODE_LO];
		nxt_ch2 = standalone_mode ? strap_ff[2] : ctrl1_ff[CHI_C1_CHAN2];
	end

	// Registers
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			ctrl0_ff <= CHI_REG_RESET;
			ctrl1_ff <= CHI_REG_RESET;
			row_ff <= '0;
			col_ff <= '0;
			osd_ff <= '0;
			osd_wr_ff <= 1'b0;
			wr_ptr_ff <= CHI_SUB_CTRL0;
			rd_ptr_ff <= CHI_SUB_RD_STATUS;
			stat_ready_ff <= 1'b0;
			stat_pshut_ff <= 1'b0;
			stat_eds_ff <= 1'b0;
			stat_field_ff <= 1'b0;
			stat_por_ff <= 1'b1;
			data1_ff <= 8'h00;
			data2_ff <= 8'h00;
			strap_ff <= 3'h0;
			mode_hi_ff <= 1'b0;
			mode_lo_ff <= 1'b0;
			ch2_ff <= 1'b0;
			dr_out_ff <= 1'b1;
			dr_oe_ff <= 1'b0;
			sda_oe_ff <= 1'b0;
		end
		else
		begin
			ctrl0_ff <= nxt_ctrl0;
			ctrl1_ff <= nxt_ctrl1;
			row_ff <= nxt_row;
			col_ff <= nxt_col;
			osd_ff <= nxt_osd;
			osd_wr_ff <= nxt_osd_wr;
			wr_ptr_ff <= nxt_wr_ptr;
			rd_ptr_ff <= nxt_rd_ptr;
			stat_ready_ff <= nxt_ready;
			stat_pshut_ff <= nxt_pshut;
			stat_eds_ff <= nxt_eds;
			stat_field_ff <= nxt_field;
			stat_por_ff <= nxt_por;
			data1_ff <= nxt_data1;
			data2_ff <= nxt_data2;
			strap_ff <= nxt_strap;
			mode_hi_ff <= nxt_mode_hi;
			mode_lo_ff <= nxt_mode_lo;
			ch2_ff <= nxt_ch2;
			dr_out_ff <= ~stat_ready_ff;
			dr_oe_ff <= dr_out_enable & ~standalone_mode;
			sda_oe_ff <= engine_oe;
		end
	end

	// Outputs straight from flops, sda_out tied to 0; SDA only ever pulls low
	assign sda_out = 1'b0;
	assign sda_oe = sda_oe_ff;
	assign data_ready_n_out = dr_out_ff;
	assign data_ready_n_oe = dr_oe_ff;
	assign ctrl0 = ctrl0_ff;
	assign display_mode_hi = mode_hi_ff;
	assign display_mode_lo = mode_lo_ff;
	assign caption_ch2 = ch2_ff;
	assign enh_mode = ctrl1_ff[CHI_C1_ENH_HI:CHI_C1_ENH_LO];
	assign acq_off = ctrl1_ff[CHI_C1_ACQ_OFF];
	assign wide_window = ctrl1_ff[CHI_C1_WIDE];
	assign clear_page = ctrl1_ff[CHI_C1_CLEAR];
	assign osd_row = row_ff;
	assign osd_col = col_ff;
	assign osd_data = osd_ff;
	assign osd_wr = osd_wr_ff;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);

	a_sub_zero_one: assert property (
		bus.wr_stb && !bus.wr_first && !standalone_mode && wr_ptr_ff == CHI_SUB_CTRL0
		|=> wr_ptr_ff == CHI_SUB_CTRL1 && ctrl0_ff == $past(bus.wr_data))
		else $error("subaddress did not move from zero to one");
	a_sub_hold_last: assert property (
		bus.wr_stb && !bus.wr_first && !standalone_mode && wr_ptr_ff == CHI_SUB_WR_LAST
		|=> wr_ptr_ff == CHI_SUB_WR_LAST)
		else $error("subaddress left the last register");
	a_regs_cleared: assert property (
		$past(reset) |-> ctrl0_ff == CHI_REG_RESET && ctrl1_ff == CHI_REG_RESET && stat_por_ff)
		else $error("registers not cleared by reset");
	a_ready_pin_low: assert property (
		acq_new_data && dr_out_enable && !standalone_mode ##1 dr_out_enable && !standalone_mode
		|=> data_ready_n_oe && !data_ready_n_out)
		else $error("data-ready pin not low after new data");
	a_ready_clean_fall: assert property (
		$fell(data_ready_n_out) |-> $past(stat_ready_ff) && !$past(stat_ready_ff, 2))
		else $error("data-ready fell without a new flag");
	a_status_set_wins: assert property (
		acq_new_data |=> stat_ready_ff)
		else $error("new data flag lost");
	a_status_rd_clear: assert property (
		bus.rd_taken && rd_ptr_ff == CHI_SUB_RD_STATUS && !acq_new_data && !acq_parity_shutdown
		|=> !stat_ready_ff && !stat_pshut_ff && !stat_por_ff && !stat_eds_ff)
		else $error("status not cleared by read");
	a_strap_channel: assert property (
		standalone_mode && !bus.busy ##1 standalone_mode |=> caption_ch2 == $past(data_ready_n_in, 2))
		else $error("channel strap decoded wrongly");
	a_strap_mode: assert property (
		standalone_mode && !bus.busy ##1 standalone_mode
		|=> {display_mode_hi, display_mode_lo} == $past({scl_in, sda_in}, 2))
		else $error("mode strap decoded wrongly");
	a_host_mode: assert property (
		!standalone_mode |=> {display_mode_hi, display_mode_lo}
		== $past({ctrl1_ff[CHI_C1_MODE_HI], ctrl1_ff[CHI_C1_MODE_LO]}))
		else $error("display mode not taken from control register one");
	c_ctrl1_written: cover property (bus.wr_stb && !bus.wr_first && wr_ptr_ff == CHI_SUB_CTRL1);
	c_status_read: cover property (rd_clear && stat_ready_ff);
	c_ready_fall: cover property ($fell(data_ready_n_out) && data_ready_n_oe);
	c_standalone: cover property (standalone_mode && display_mode_hi && caption_ch2);

endmodule // chi_caption_host_interface

`default_nettype wire

/* File: chi_host_model.sv */
// Purpose: Behavioural two-wire bus host for the caption interface.
// Assumes: SDA is open drain with a pull-up; the resolved line comes back.
// Notes:   hp is a quarter of the SCL period in mclk cycles, 3 or more.
`timescale 1ns/1ps
`default_nettype none

module chi_host_model (
	// Clock
	input wire logic mclk,
	// Bus lines
	input wire logic sda_line,
	output logic scl_drv,
	output logic sda_drv
);
	int hp = 4;
	int n_nack = 0;

	// Idle bus: both lines released high
	initial
	begin
		scl_drv = 1'b1;
		sda_drv = 1'b1;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
	endtask

	// One SCL period; data moves only while SCL is low
	task automatic clk_bit(input logic b, output logic got);
		scl_drv <= 1'b0;
		tick(hp);
		sda_drv <= b;
		tick(hp);
		scl_drv <= 1'b1;
		tick(hp);
		got = sda_line;
		tick(hp);
	endtask

	// Start or repeated start
	task automatic start_cond();
		scl_drv <= 1'b0;
		tick(hp);
		sda_drv <= 1'b1;
		tick(hp);
		scl_drv <= 1'b1;
		tick(hp);
		sda_drv <= 1'b0;
		tick(hp);
	endtask

	task automatic stop_cond();
		scl_drv <= 1'b0;
		tick(hp);
		sda_drv <= 1'b0;
		tick(hp);
		scl_drv <= 1'b1;
		tick(hp);
		sda_drv <= 1'b1;
		tick(hp);
	endtask

	// Eight bits MSB first, then the acknowledge slot
	task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
		output logic ack);
		for (int i = 7; i >= 0; i--)
			clk_bit(tx[i], rx[i]);
		clk_bit(ack_in, ack);
	endtask

	// Write from a subaddress; a missing ack is counted
	task automatic wr(input logic [7:0] sub, input logic [7:0] d[$]);
		logic [7:0] rx;
		logic ack;
		start_cond();
		xfer({chi_pkg::CHI_DEV_ADDR_DEFAULT, 1'b0}, 1'b1, rx, ack);
		n_nack += int'(ack);
		xfer(sub, 1'b1, rx, ack);
		n_nack += int'(ack);
		foreach (d[i])
		begin
			xfer(d[i], 1'b1, rx, ack);
			n_nack += int'(ack);
		end
		stop_cond();
	endtask

	// Set the subaddress, repeated start, read n bytes, NACK the last
	task automatic rd(input logic [7:0] sub, input int n, output logic [7:0] q[$]);
		logic [7:0] rx;
		logic ack;
		q = {};
		start_cond();
		xfer({chi_pkg::CHI_DEV_ADDR_DEFAULT, 1'b0}, 1'b1, rx, ack);
		n_nack += int'(ack);
		xfer(sub, 1'b1, rx, ack);
		n_nack += int'(ack);
		start_cond();
		xfer({chi_pkg::CHI_DEV_ADDR_DEFAULT, 1'b1}, 1'b1, rx, ack);
		n_nack += int'(ack);
		for (int i = 0; i < n; i++)
		begin
			xfer(8'hff, logic'(i == n - 1), rx, ack);
			q.push_back(rx);
		end
		stop_cond();
	endtask

	// Straps: a STOP first, then levels set with SCL low so no START appears
	task automatic strap(input logic s, input logic d);
		stop_cond();
		scl_drv <= 1'b0;
		tick(hp);
		sda_drv <= d;
		tick(hp);
		scl_drv <= s;
		tick(hp);
	endtask
endmodule // chi_host_model

`default_nettype wire

/* File: chi_caption_host_interface_tb.sv */
// Purpose: Self-checking bench for the caption host interface.
// Assumes: Host model owns SCL/SDA; pull-ups on SDA and data-ready.
// Notes:   Expected values come from a small integer model here.
`timescale 1ns/1ps
`default_nettype none

module chi_caption_host_interface_tb;
	import chi_pkg::*;

	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic mclk, reset, sda_out, sda_oe, dr_n_out, dr_n_oe, scl_drv, sda_drv, dr_strap;
	logic standalone_mode, dr_out_enable, acq_new_data, acq_parity_shutdown, acq_eds, acq_field2;
	logic [7:0] acq_byte1, acq_byte2, ctrl0, a, b, r8, c8, m_status;
	logic dm_hi, dm_lo, ch2, acq_off, wide, clr, osd_wr;
	logic [1:0] enh;
	logic [3:0] row;
	logic [4:0] col;
	logic [6:0] osd;
	logic [7:0] q[$];
	int n_fail = 0;
	int compares = 0;
	int n_osd_wr = 0;
	int seed = 32'h6753;
	wire logic sda_line;
	wire logic dr_line;
	wire logic [7:0] ctrl1_v;

	// Pull-ups resolve released lines high
	assign sda_line = sda_drv & ~sda_oe;
	assign dr_line = dr_n_oe ? dr_n_out : dr_strap;
	assign ctrl1_v = {clr, ch2, wide, acq_off, enh, dm_hi, dm_lo};

	// Count display-data write pulses; a stretched pulse would show up as extra counts
	always @(posedge mclk)
		if (osd_wr === 1'b1)
			n_osd_wr++;

	chi_caption_host_interface u_chi_caption_host_interface (.mclk(mclk), .reset(reset),
		.scl_in(scl_drv), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
		.data_ready_n_in(dr_line), .data_ready_n_out(dr_n_out), .data_ready_n_oe(dr_n_oe),
		.standalone_mode(standalone_mode), .dr_out_enable(dr_out_enable),
		.acq_new_data(acq_new_data), .acq_parity_shutdown(acq_parity_shutdown),
		.acq_eds(acq_eds), .acq_field2(acq_field2), .acq_byte1(acq_byte1),
		.acq_byte2(acq_byte2), .ctrl0(ctrl0), .display_mode_hi(dm_hi),
		.display_mode_lo(dm_lo), .caption_ch2(ch2), .enh_mode(enh), .acq_off(acq_off),
		.wide_window(wide), .clear_page(clr), .osd_row(row), .osd_col(col),
		.osd_data(osd), .osd_wr(osd_wr));

	chi_host_model u_chi_host_model (.mclk(mclk), .sda_line(sda_line), .scl_drv(scl_drv),
		.sda_drv(sda_drv));

	// ----------------------------------------------------------------
	// Clock, compare and closing
	// ----------------------------------------------------------------
	initial
	begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp)
		begin
			n_fail++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic stop_test();
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// Watchdog: the full run needs well under 20k cycles
	initial
	begin
		repeat (50000) @(posedge mclk);
		n_fail++;
		stop_test();
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		reset = 1'b1;
		standalone_mode = 1'b0;
		dr_out_enable = 1'b1;
		acq_new_data = 1'b0;
		acq_parity_shutdown = 1'b0;
		acq_eds = 1'b0;
		acq_field2 = 1'b0;
		acq_byte1 = 8'h00;
		acq_byte2 = 8'h00;
		dr_strap = 1'b1;
		repeat (20) @(posedge mclk);
		reset <= 1'b0;
		repeat (2) @(posedge mclk);
		#1;
		chk(ctrl0, 8'h00);
		chk(ctrl1_v, 8'h00);
		chk({7'h0, dr_line}, 8'h01);
		// Configuration write, two bytes from subaddress zero
		a = 8'($random(seed));
		b = 8'($random(seed));
		u_chi_host_model.wr(8'h00, '{a, b});
		chk(ctrl0, a);
		chk(ctrl1_v, b);
		// Slow host; pointer climbs to the data register and holds there
		u_chi_host_model.hp = 7;
		r8 = 8'($random(seed));
		c8 = 8'($random(seed)) & 8'h0f;
		u_chi_host_model.wr(8'h02, '{r8, c8, a, b});
		chk({4'h0, row}, {4'h0, r8[3:0]});
		chk({3'h0, col}, c8 + 8'h02);
		chk({1'b0, osd}, {1'b0, b[6:0]});
		chk(8'(n_osd_wr), 8'h02);
		// New data: pin falls two cycles after the pulse
		u_chi_host_model.hp = 4;
		a = 8'($random(seed));
		b = 8'($random(seed));
		acq_byte1 <= a;
		acq_byte2 <= b;
		acq_eds <= a[0];
		acq_field2 <= b[0];
		acq_new_data <= 1'b1;
		acq_parity_shutdown <= 1'b1;
		@(posedge mclk);
		acq_new_data <= 1'b0;
		acq_parity_shutdown <= 1'b0;
		// Flag is set at this edge; the pin still stands high for one more cycle
		#1;
		chk({7'h0, dr_line}, 8'h01);
		@(posedge mclk);
		#1;
		chk({7'h0, dr_line}, 8'h00);
		m_status = {4'h8, b[0], a[0], 2'b11};
		u_chi_host_model.rd(8'h00, 3, q);
		chk(q[0], m_status);
		chk(q[1], a);
		chk(q[2], b);
		chk({7'h0, dr_line}, 8'h01);
		u_chi_host_model.rd(8'h00, 1, q);
		chk(q[0], 8'h00);
		// Stand-alone strap sweep over all eight combinations
		standalone_mode <= 1'b1;
		for (int k = 0; k < 8; k++)
		begin
			@(posedge mclk);
			dr_strap <= k[2];
			u_chi_host_model.strap(k[1], k[0]);
			repeat (6) @(posedge mclk);
			#1;
			chk({5'h0, ch2, dm_hi, dm_lo}, 8'(k));
		end
		// Host writes are discarded while stand-alone
		a = ctrl0;
		u_chi_host_model.wr(8'h00, '{~a, ~a});
		chk(ctrl0, a);
		chk(8'(u_chi_host_model.n_nack), 8'h00);
		chk({7'h0, sda_out}, 8'h00);
		stop_test();
	end
endmodule // chi_caption_host_interface_tb

`default_nettype wire
